/* File: verilog/scg_pkg.sv */
// Package for the charge-state warning flags and load-model selector
package scg_pkg;
  // Data widths
  localparam int CAP_W = 16;
  localparam int CUR_W = 16;
  localparam int VOLT_W = 16;
  localparam int SEL_W = 3;
  // Load-mode encodings
  localparam logic LOAD_MODE_CC = 1'h0;
  localparam logic LOAD_MODE_CP = 1'h1;
  localparam logic LOAD_MODE_RST = 1'h0;
  // Load-select codes
  localparam logic [2:0] SEL_PREV_AVG = 3'h0;
  localparam logic [2:0] SEL_PRES_AVG = 3'h1;
  localparam logic [2:0] SEL_AVG = 3'h2;
  localparam logic [2:0] SEL_FILT = 3'h3;
  localparam logic [2:0] SEL_DESIGN5 = 3'h4;
  localparam logic [2:0] SEL_HOST = 3'h5;
  localparam logic [2:0] SEL_USER = 3'h6;
  // Reset values
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] DISABLED_THR = 16'hffff;
  localparam logic [15:0] DIV_FIVE = 16'h0005;
  // Filter time constant
  localparam int CLK_HZ = 10000000;
  localparam int FILT_TAU_S = 14;
  localparam int FILT_SHIFT = 4;
  // Accumulator fractional bits
  localparam int ACC_FRAC = 8;
  localparam logic [1:0] CNT_RST = 2'h0;

  // Host configuration group
  typedef struct packed {
    logic [15:0] first_set;
    logic [15:0] first_clear;
    logic [15:0] final_set;
    logic [15:0] final_clear;
    logic        load_mode;
    logic [2:0]  load_select;
    logic        reserve_noload_comp_bit;
    logic [15:0] reserve_cap;
    logic [15:0] host_rate_value;
    logic [15:0] user_current_rate;
    logic [15:0] user_power_rate;
    logic [15:0] design_capacity;
    logic [15:0] design_energy;
  } scg_cfg_t;

  // Status flag group
  typedef struct packed {
    logic low_charge_warn_first;
    logic low_charge_warn_final;
    logic internal_short_flag;
    logic tab_disconnect_flag;
    logic load_model_status_bit;
  } scg_flags_t;
endpackage

/* File: verilog/scg_top.sv */
// Charge-state warning flags, fault flags and load-model rate selection
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Accumulate signed charge samples into the capacity estimate, both directions.
// RULE_02: Set first warning when remaining capacity drops below first set threshold.
// RULE_03: Clear first warning only when capacity rises above first clear threshold.
// RULE_04: Set final warning when capacity drops below final set threshold.
// RULE_05: Final set threshold of minus one disables setting the final warning.
// RULE_06: Clear final warning above final clear threshold, only when already set.
// RULE_07: Raise internal-short flag on a short seen while battery relaxed.
// RULE_08: Raise tab-disconnect flag on a health event in two-cell parallel pack.
// RULE_09: Load mode 0 selects constant current, 1 constant power; default 0.
// RULE_10: Mirror load mode into a status bit readable by the host.
// RULE_11: Current codes 0,1,2 pick previous, present, and plain average current.
// RULE_12: Current code 3 picks low-pass filtered average current, 14 s constant.
// RULE_13: Current codes 4,5,6 pick design capacity/5, host rate, user current rate.
// RULE_14: Power codes 0,1,2 pick previous, present average power, current times voltage.
// RULE_15: Power code 3 picks voltage times filtered average current.
// RULE_16: Power codes 4,5,6 pick design energy/5, host rate, user power rate.
// RULE_17: Keep programmable reserve capacity beyond zero reported remaining capacity.
// RULE_18: Reserve uses loaded or no-load compensation per configuration bit.
// RULE_19: Report full charge capacity compensated for the present load.
// RULE_20: Also report uncompensated remaining and full capacities.
// RULE_21: Reserve bit set selects no-load compensation; resets to zero.
// RULE_22: Evaluate thresholds on each capacity update; hold warning flags between updates.
module scg_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Host configuration
  input  wire scg_pkg::scg_cfg_t         cfg,
  // Measurement inputs from same-clock logic
  input  wire logic                      sample_valid,
  input  wire logic signed [15:0]        charge_delta,
  input  wire logic [15:0]               full_capacity_raw,
  input  wire logic [15:0]               load_drop,
  input  wire logic [15:0]               averaged_current,
  input  wire logic [15:0]               prev_avg_current,
  input  wire logic [15:0]               pres_avg_current,
  input  wire logic [15:0]               prev_avg_power,
  input  wire logic [15:0]               pres_avg_power,
  input  wire logic [15:0]               cell_voltage,
  input  wire logic                      relaxed,
  input  wire logic                      short_detect,
  input  wire logic                      parallel_two_cell,
  input  wire logic                      tab_detect,
  // Status outputs
  output logic                           cap_update,
  output scg_pkg::scg_flags_t            flags,
  output logic [15:0]                    remaining_capacity_a,
  output logic [15:0]                    full_charge_capacity_b,
  output logic [15:0]                    uncomp_remaining_capacity,
  output logic [15:0]                    uncomp_full_capacity,
  output logic [15:0]                    reserve_capacity,
  output logic [31:0]                    load_rate
);
  import scg_pkg::*;

  // Whole module state
  typedef struct packed {
    logic signed [23:0] charge_acc;
    logic [23:0]        filt_acc;
    logic               upd;
    scg_flags_t         fl;
    logic [15:0]        rem;
    logic [15:0]        fcc;
    logic [15:0]        urem;
    logic [15:0]        ufcc;
    logic [15:0]        rsv;
    logic [31:0]        rate;
  } scg_state_t;

  scg_state_t st;
  scg_state_t next_st;

  // Filter shift approximates a 14 s time constant on one-second samples
  localparam int FILT_TAU_CYC = FILT_TAU_S * CLK_HZ;

  logic [15:0] filt_cur;
  logic [31:0] sel_val;
  logic [15:0] comp_rsv;
  logic [16:0] cap_sum;
  logic signed [24:0] acc_sum;

  assign filt_cur = st.filt_acc[23 -: 16];

  // Rate source selection
  always_comb begin
    sel_val = 32'h0;
    if (cfg.load_mode == LOAD_MODE_CC) begin
      case (cfg.load_select)
        SEL_PREV_AVG: sel_val = {16'h0, prev_avg_current}; // RULE_11
        SEL_PRES_AVG: sel_val = {16'h0, pres_avg_current}; // RULE_11
        SEL_AVG:      sel_val = {16'h0, averaged_current}; // RULE_11
        SEL_FILT:     sel_val = {16'h0, filt_cur}; // RULE_12
        SEL_DESIGN5:  sel_val = {16'h0, cfg.design_capacity / DIV_FIVE}; // RULE_13
        SEL_HOST:     sel_val = {16'h0, cfg.host_rate_value}; // RULE_13
        SEL_USER:     sel_val = {16'h0, cfg.user_current_rate}; // RULE_13
        default:      sel_val = {16'h0, pres_avg_current};
      endcase
    end else begin
      case (cfg.load_select)
        SEL_PREV_AVG: sel_val = {16'h0, prev_avg_power}; // RULE_14
        SEL_PRES_AVG: sel_val = {16'h0, pres_avg_power}; // RULE_14
        SEL_AVG:      sel_val = averaged_current * cell_voltage; // RULE_14
        SEL_FILT:     sel_val = filt_cur * cell_voltage; // RULE_15
        SEL_DESIGN5:  sel_val = {16'h0, cfg.design_energy / DIV_FIVE}; // RULE_16
        SEL_HOST:     sel_val = {16'h0, cfg.host_rate_value}; // RULE_16
        SEL_USER:     sel_val = {16'h0, cfg.user_power_rate}; // RULE_16
        default:      sel_val = {16'h0, prev_avg_power};
      endcase
    end
  end

  // Reserve compensation: loaded rate adds the present load drop
  always_comb begin
    cap_sum = {1'b0, cfg.reserve_cap} + {1'b0, load_drop};
    if (cfg.reserve_noload_comp_bit) begin
      comp_rsv = cfg.reserve_cap; // RULE_21
    end else if (cap_sum[16]) begin
      comp_rsv = 16'hffff;
    end else begin
      comp_rsv = cap_sum[15:0]; // RULE_18
    end
  end

  // Next-state logic
  always_comb begin
    logic [15:0] avail;
    logic [15:0] comp_full;
    logic [15:0] comp_rem;
    logic [15:0] cap_q;
    avail = 16'h0;
    comp_full = 16'h0;
    comp_rem = 16'h0;
    cap_q = 16'h0;
    next_st = st;
    next_st.upd = 1'b0;
    acc_sum = 25'(st.charge_acc) + 25'(charge_delta);
    // Level flag copy of load mode for the host
    next_st.fl.load_model_status_bit = cfg.load_mode; // RULE_09 RULE_10
    next_st.rate = sel_val;
    next_st.rsv = comp_rsv; // RULE_17
    // Sticky fault flags; only reset clears them
    if (relaxed && short_detect) begin
      next_st.fl.internal_short_flag = 1'b1; // RULE_07
    end
    if (parallel_two_cell && tab_detect) begin
      next_st.fl.tab_disconnect_flag = 1'b1; // RULE_08
    end
    if (sample_valid) begin
      // Saturate so a long discharge cannot wrap to full
      if (acc_sum < 25'sh0) begin
        next_st.charge_acc = 24'sh0; // RULE_01
      end else if (acc_sum > 25'sh7fffff) begin
        next_st.charge_acc = 24'sh7fffff;
      end else begin
        next_st.charge_acc = acc_sum[23:0]; // RULE_01
      end
      next_st.filt_acc = st.filt_acc - (st.filt_acc >> FILT_SHIFT)
                         + ({8'h0, averaged_current} << (ACC_FRAC - FILT_SHIFT)); // RULE_12
      cap_q = next_st.charge_acc[23 -: 16] > full_capacity_raw ?
              full_capacity_raw : 16'(next_st.charge_acc[23:ACC_FRAC - 1] >> 1);
      avail = cap_q;
      comp_full = full_capacity_raw > load_drop ? full_capacity_raw - load_drop : 16'h0;
      // Widen the sum so a large load drop plus reserve cannot wrap to a small value
      comp_rem = ({1'b0, avail} > ({1'b0, load_drop} + {1'b0, comp_rsv})) ?
                 avail - load_drop - comp_rsv : 16'h0;
      next_st.urem = avail; // RULE_20
      next_st.ufcc = full_capacity_raw; // RULE_20
      next_st.fcc = comp_full; // RULE_19
      next_st.rem = comp_rem; // RULE_17
      next_st.upd = 1'b1; // RULE_22
      // Hysteresis; set wins if both thresholds overlap
      if (comp_rem < cfg.first_set) begin
        next_st.fl.low_charge_warn_first = 1'b1; // RULE_02
      end else if (comp_rem > cfg.first_clear) begin
        next_st.fl.low_charge_warn_first = 1'b0; // RULE_03
      end
      if (cfg.final_set != DISABLED_THR && comp_rem < cfg.final_set) begin
        next_st.fl.low_charge_warn_final = 1'b1; // RULE_04 RULE_05
      end else if (st.fl.low_charge_warn_final && comp_rem > cfg.final_clear) begin
        next_st.fl.low_charge_warn_final = 1'b0; // RULE_06
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign cap_update = st.upd;
  assign flags = st.fl;
  assign remaining_capacity_a = st.rem;
  assign full_charge_capacity_b = st.fcc;
  assign uncomp_remaining_capacity = st.urem;
  assign uncomp_full_capacity = st.ufcc;
  assign reserve_capacity = st.rsv;
  assign load_rate = st.rate;

  // Assertions
  property p_first_set;
    @(posedge clk) disable iff (!resetn)
      (cap_update && remaining_capacity_a < $past(cfg.first_set)) |-> flags.low_charge_warn_first;
  endproperty
  a_first_set: assert property (p_first_set) else $error("first warn not set"); // RULE_02

  property p_first_hold;
    @(posedge clk) disable iff (!resetn)
      !sample_valid |=> $stable(flags.low_charge_warn_first);
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("first warn moved"); // RULE_22

  property p_first_clear;
    @(posedge clk) disable iff (!resetn)
      $fell(flags.low_charge_warn_first) |-> remaining_capacity_a > $past(cfg.first_clear);
  endproperty
  a_first_clear: assert property (p_first_clear) else $error("first warn bad clear"); // RULE_03

  property p_final_off;
    @(posedge clk) disable iff (!resetn)
      (cfg.final_set == DISABLED_THR && !flags.low_charge_warn_final)
        |=> !flags.low_charge_warn_final;
  endproperty
  a_final_off: assert property (p_final_off) else $error("final warn set when off"); // RULE_05

  property p_final_set;
    @(posedge clk) disable iff (!resetn)
      (cap_update && $past(cfg.final_set) != DISABLED_THR
        && remaining_capacity_a < $past(cfg.final_set)) |-> flags.low_charge_warn_final;
  endproperty
  a_final_set: assert property (p_final_set) else $error("final warn not set"); // RULE_04

  property p_isd;
    @(posedge clk) disable iff (!resetn)
      (relaxed && short_detect) |=> flags.internal_short_flag [*2];
  endproperty
  a_isd: assert property (p_isd) else $error("short flag missing"); // RULE_07

  property p_tdd;
    @(posedge clk) disable iff (!resetn)
      $rose(flags.tab_disconnect_flag) |-> $past(parallel_two_cell && tab_detect);
  endproperty
  a_tdd: assert property (p_tdd) else $error("tab flag without cause"); // RULE_08

  property p_load_model_status_bit;
    @(posedge clk) disable iff (!resetn)
      ##1 flags.load_model_status_bit == $past(cfg.load_mode);
  endproperty
  a_load_model_status_bit: assert property (p_load_model_status_bit) else $error("load mode status wrong"); // RULE_10

  property p_host_rate;
    @(posedge clk) disable iff (!resetn)
      (cfg.load_select == SEL_HOST) |=> load_rate == {16'h0, $past(cfg.host_rate_value)};
  endproperty
  a_host_rate: assert property (p_host_rate) else $error("host rate not used"); // RULE_13

  property p_reserve_noload_comp_bit;
    @(posedge clk) disable iff (!resetn)
      cfg.reserve_noload_comp_bit |=> reserve_capacity == $past(cfg.reserve_cap);
  endproperty
  a_reserve_noload_comp_bit: assert property (p_reserve_noload_comp_bit) else $error("no-load reserve wrong"); // RULE_21

  // One capacity update is taken, then answered on the next edge
  sequence s_take;
    sample_valid;
  endsequence
  sequence s_answer;
    cap_update;
  endsequence

  property p_upd_pulse;
    @(posedge clk) disable iff (!resetn)
      s_take |=> s_answer;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update not answered"); // RULE_22

  property p_upd_only;
    @(posedge clk) disable iff (!resetn)
      !sample_valid |=> !cap_update;
  endproperty
  a_upd_only: assert property (p_upd_only) else $error("update without sample"); // RULE_22

  property p_first_rise;
    @(posedge clk) disable iff (!resetn)
      $rose(flags.low_charge_warn_first)
        |-> cap_update && (remaining_capacity_a < $past(cfg.first_set));
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first warn set early"); // RULE_02

  property p_final_rise;
    @(posedge clk) disable iff (!resetn)
      $rose(flags.low_charge_warn_final)
        |-> cap_update && ($past(cfg.final_set) != DISABLED_THR)
            && (remaining_capacity_a < $past(cfg.final_set));
  endproperty
  a_final_rise: assert property (p_final_rise) else $error("final warn set early"); // RULE_05

  property p_final_clear;
    @(posedge clk) disable iff (!resetn)
      $fell(flags.low_charge_warn_final) |-> remaining_capacity_a > $past(cfg.final_clear);
  endproperty
  a_final_clear: assert property (p_final_clear) else $error("final warn bad clear"); // RULE_06

  property p_isd_cause;
    @(posedge clk) disable iff (!resetn)
      $rose(flags.internal_short_flag) |-> $past(relaxed && short_detect);
  endproperty
  a_isd_cause: assert property (p_isd_cause) else $error("short flag without cause"); // RULE_07

  property p_tdd_sticky;
    @(posedge clk) disable iff (!resetn)
      flags.tab_disconnect_flag |=> flags.tab_disconnect_flag;
  endproperty
  a_tdd_sticky: assert property (p_tdd_sticky) else $error("tab flag dropped"); // RULE_08

  property p_cc_prev;
    @(posedge clk) disable iff (!resetn)
      (cfg.load_mode == LOAD_MODE_CC && cfg.load_select == SEL_PREV_AVG)
        |=> load_rate == {16'h0, $past(prev_avg_current)};
  endproperty
  a_cc_prev: assert property (p_cc_prev) else $error("previous current not used"); // RULE_11

  property p_cp_prod;
    @(posedge clk) disable iff (!resetn)
      (cfg.load_mode == LOAD_MODE_CP && cfg.load_select == SEL_AVG)
        |=> load_rate == $past(averaged_current) * $past(cell_voltage);
  endproperty
  a_cp_prod: assert property (p_cp_prod) else $error("power product wrong"); // RULE_14

  property p_rsv_loaded;
    @(posedge clk) disable iff (!resetn)
      (!cfg.reserve_noload_comp_bit
        && ({1'b0, cfg.reserve_cap} + {1'b0, load_drop} < 17'h10000))
        |=> reserve_capacity == $past(cfg.reserve_cap) + $past(load_drop);
  endproperty
  a_rsv_loaded: assert property (p_rsv_loaded) else $error("loaded reserve wrong"); // RULE_18

  property p_rem_floor;
    @(posedge clk) disable iff (!resetn)
      cap_update |-> remaining_capacity_a <= uncomp_remaining_capacity;
  endproperty
  a_rem_floor: assert property (p_rem_floor) else $error("remaining above light-load"); // RULE_17

  property p_fcc_bound;
    @(posedge clk) disable iff (!resetn)
      cap_update |-> full_charge_capacity_b <= uncomp_full_capacity;
  endproperty
  a_fcc_bound: assert property (p_fcc_bound) else $error("full charge above light-load"); // RULE_19
endmodule

/* File: testbench/scg_host_model.sv */
// Host-side partner: holds the gauge configuration and logs reported flags
`timescale 1ns/1ps
module scg_host_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Configuration writes from the bench
  input  wire logic                wr,
  input  wire scg_pkg::scg_cfg_t   wr_cfg,
  // Gauge side
  input  wire logic                cap_update,
  input  wire scg_pkg::scg_flags_t flags,
  output scg_pkg::scg_cfg_t        cfg,
  output scg_pkg::scg_flags_t      seen_flags
);
  import scg_pkg::*;
  // Flags are logged only at an update; between updates the warning flags hold, but fault and mode bits can change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= {64'h0, LOAD_MODE_RST, SEL_PRES_AVG, 1'h0, 112'h0};
      seen_flags <= '0;
    end else begin
      if (wr)
        cfg <= wr_cfg;
      if (cap_update)
        seen_flags <= flags;
    end
  end
endmodule

/* File: testbench/scg_top_tb_top.sv */
// Self-checking bench for the warning flags and load-model selector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module scg_top_tb_top;
  import scg_pkg::*;
  logic clk, resetn, wr, sample_valid, relaxed, short_detect, par2, tab_detect, cap_update;
  logic signed [15:0] charge_delta;
  logic [15:0] raw, load_drop, rem, fcc, urem, ufull, rsv, avg_cur;
  logic [31:0] load_rate, exp_rate;
  scg_cfg_t c, wr_cfg, cfg;
  scg_flags_t flags, seen_flags;
  int errors = 0, n_tests = 0, cyc = 0;
  // Rows: charge delta, remaining capacity, first warning, final warning
  localparam logic [33:0] ROWS [8] = '{{16'h6400, 16'h0064, 2'h2}, {16'hce00, 16'h0032, 2'h3},
    {16'h6400, 16'h0096, 2'h3}, {16'h6400, 16'h00fa, 2'h2}, {16'h6400, 16'h015e, 2'h2},
    {16'h6400, 16'h01c2, 2'h0}, {16'h9c00, 16'h015e, 2'h0}, {16'h9c00, 16'h00fa, 2'h2}};

  scg_host_model i_scg_host_model (.clk(clk), .resetn(resetn), .wr(wr), .wr_cfg(wr_cfg),
    .cap_update(cap_update), .flags(flags), .cfg(cfg), .seen_flags(seen_flags));
  scg_top i_scg_top (.clk(clk), .resetn(resetn), .cfg(cfg), .sample_valid(sample_valid),
    .charge_delta(charge_delta), .full_capacity_raw(raw), .load_drop(load_drop),
    .averaged_current(avg_cur), .prev_avg_current(16'h000b), .pres_avg_current(16'h000c),
    .prev_avg_power(16'h001f), .pres_avg_power(16'h0020), .cell_voltage(16'h0007),
    .relaxed(relaxed), .short_detect(short_detect), .parallel_two_cell(par2),
    .tab_detect(tab_detect), .cap_update(cap_update), .flags(flags),
    .remaining_capacity_a(rem), .full_charge_capacity_b(fcc), .uncomp_remaining_capacity(urem),
    .uncomp_full_capacity(ufull), .reserve_capacity(rsv), .load_rate(load_rate));

  // Free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Host write; the model latches it, then one edge lets registered outputs follow
  task automatic set_cfg();
    @(posedge clk) wr <= 1'b1;
    wr_cfg <= c;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk) #1;
  endtask
  // One capacity update; the answer stands for exactly one cycle
  task automatic sample(input logic [15:0] d);
    @(posedge clk) sample_valid <= 1'b1;
    charge_delta <= d;
    @(posedge clk) sample_valid <= 1'b0;
    #1 `CHK("cap_update", 1'b1, cap_update)
    @(posedge clk) #1 `CHK("cap_update", 1'b0, cap_update)
  endtask

  initial begin
    {resetn, wr, sample_valid, relaxed, short_detect, par2, tab_detect} = '0;
    {charge_delta, load_drop} = '0;
    raw = 16'hffff;
    avg_cur = 16'h000d;
    wr_cfg = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1 `CHK("flags", 5'h0, flags)
    `CHK("remaining", 16'h0, rem)
    `CHK("load_mode", LOAD_MODE_CC, cfg.load_mode)
    `CHK("comp_bit", 1'b0, cfg.reserve_noload_comp_bit)
    c = cfg;
    {c.first_set, c.first_clear, c.final_set, c.final_clear} = {16'd300, 16'd400, 16'd100, 16'd200};
    {c.design_capacity, c.design_energy} = {16'd500, 16'd1000};
    {c.host_rate_value, c.user_current_rate, c.user_power_rate} = {16'd21, 16'd22, 16'd33};
    set_cfg();
    // Hysteresis walk: strict comparison checked at the final set boundary
    foreach (ROWS[i]) begin
      sample(ROWS[i][33:18]);
      `CHK("remaining", ROWS[i][17:2], rem)
      `CHK("warn_first", ROWS[i][1], flags.low_charge_warn_first)
      `CHK("warn_final", ROWS[i][0], flags.low_charge_warn_final)
    end
    `CHK("host_log", flags, seen_flags)
    // Threshold change with no update must not move the flags
    c.first_set = 16'd100;
    set_cfg();
    `CHK("warn_first", 1'b1, flags.low_charge_warn_first)
    c.first_set = 16'd300;
    c.final_set = DISABLED_THR;
    set_cfg();
    sample(16'h9c00);
    sample(16'h9c00);
    `CHK("warn_final", 1'b0, flags.low_charge_warn_final)
    c.final_set = 16'd100;
    set_cfg();
    sample(16'h0000);
    `CHK("warn_final", 1'b1, flags.low_charge_warn_final)
    // A long run of updates on a steady current lets the filter settle on it
    repeat (100) sample(16'h0000);
    // Both load models over every code, settled filter and spare code included
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        c.load_mode = m[0];
        c.load_select = s[2:0];
        set_cfg();
        case (s)
          0: exp_rate = m ? 32'd31 : 32'd11;
          1: exp_rate = m ? 32'd32 : 32'd12;
          2: exp_rate = m ? 32'd91 : 32'd13;
          3: exp_rate = m ? 32'd91 : 32'd13;
          4: exp_rate = m ? 32'd200 : 32'd100;
          5: exp_rate = 32'd21;
          7: exp_rate = m ? 32'd31 : 32'd12;
          default: exp_rate = m ? 32'd33 : 32'd22;
        endcase
        `CHK("load_rate", exp_rate, load_rate)
        `CHK("mode_status", m[0], flags.load_model_status_bit)
      end
    end
    // A current step shows only partly through the filter on code 3
    c.load_mode = LOAD_MODE_CC;
    c.load_select = SEL_FILT;
    set_cfg();
    @(posedge clk) avg_cur <= 16'h00d0;
    sample(16'h0000);
    `CHK("filt_lag", 1'b1, (load_rate > 32'd13) && (load_rate < 32'd208))
    // Reserve under both compensation choices, then past empty
    load_drop <= 16'd10;
    raw <= 16'd1000;
    c.reserve_cap = 16'd5;
    c.reserve_noload_comp_bit = 1'b1;
    set_cfg();
    sample(16'h0000);
    `CHK("reserve", 16'd5, rsv)
    `CHK("remaining", 16'd35, rem)
    `CHK("full_charge", 16'd990, fcc)
    `CHK("uncomp_full", 16'd1000, ufull)
    `CHK("uncomp_rem", 16'd50, urem)
    c.reserve_noload_comp_bit = 1'b0;
    set_cfg();
    sample(16'h0000);
    `CHK("reserve", 16'd15, rsv)
    `CHK("remaining", 16'd25, rem)
    c.reserve_cap = 16'd100;
    set_cfg();
    sample(16'h0000);
    `CHK("remaining", 16'd0, rem)
    // Fault flags need their qualifier, then stay up
    @(posedge clk) short_detect <= 1'b1;
    tab_detect <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("short", 1'b0, flags.internal_short_flag)
    `CHK("tab", 1'b0, flags.tab_disconnect_flag)
    @(posedge clk) relaxed <= 1'b1;
    par2 <= 1'b1;
    @(posedge clk) {relaxed, par2, short_detect, tab_detect} <= 4'h0;
    repeat (3) @(posedge clk);
    #1 `CHK("short", 1'b1, flags.internal_short_flag)
    `CHK("tab", 1'b1, flags.tab_disconnect_flag)
    // Second reset in mid-run clears everything
    @(posedge clk) resetn <= 1'b0;
    load_drop <= 16'h0000;
    @(posedge clk) #1 `CHK("flags", 5'h0, flags)
    `CHK("remaining", 16'h0, rem)
    @(posedge clk) resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("flags", 5'h0, flags)
    `CHK("reserve", 16'h0, rsv)
    // The accumulator restarts from empty after the reset
    sample(16'h0a00);
    `CHK("uncomp_rem", 16'd10, urem)
    `CHK("remaining", 16'd10, rem)
    final_report();
  end
endmodule
